/* pcg_checker.sv */
// Purpose: Port assertions for the clock gating block.
// Assumes: Writes count only while pclken is high.
// Notes: Enables follow a write two sampled edges later.
`timescale 1ns/10ps
module pcg_checker #(parameter NUM_PERIPH = 6) (
    input wire pclk, presetn, psel, penable, pwrite, pslverr, // Bus.
    input wire pclken, // Clock enable.
    input wire sleep_mode, deep_sleep_mode, // Power state.
    input wire [11:0] paddr, // Address.
    input wire [31:0] pwdata, prdata, // Data.
    input wire [NUM_PERIPH-1:0] periph_access, periph_clk_en, // Units.
    input wire [NUM_PERIPH-1:0] periph_fault // Faults.
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire run = !sleep_mode && !deep_sleep_mode;
    wire wr = psel && penable && pwrite && pclken;
    wire rd = psel && penable && !pwrite;
    wire [NUM_PERIPH-1:0] gated = periph_access & ~periph_clk_en;
    a_fault_mask: assert property (periph_fault == gated)
        else $error("fault mask");
    a_reset_off: assert property ($rose(presetn) |-> periph_clk_en == 0)
        else $error("enables after reset");
    a_run1_write: assert property (
        wr && paddr == 12'h104 && run ##1 run |=> periph_clk_en[5:3] ==
        {$past(pwdata[24], 2), $past(pwdata[18], 2), $past(pwdata[17], 2)})
        else $error("run bank1 enables");
    a_run0_write: assert property (
        wr && paddr == 12'h100 && run ##1 run |=> periph_clk_en[2:0] ==
        {$past(pwdata[20], 2), $past(pwdata[16], 2), $past(pwdata[3], 2)})
        else $error("run bank0 enables");
    a_bank1_rsvd: assert property (rd && paddr == 12'h104 |->
        (prdata & ~32'h01060000) == 0) else $error("bank1 reserved");
    a_bank0_rsvd: assert property (rd && paddr == 12'h120 |->
        (prdata & ~32'h00110008) == 32'h40) else $error("bank0 reserved");
    a_status_read: assert property (rd && paddr == 12'h130 |->
        prdata[5:0] == $past(periph_clk_en[5:0])) else $error("status");
    a_gate_hold: assert property (
        (!psel && $stable(sleep_mode) && $stable(deep_sleep_mode)) [*3]
        |-> $stable(periph_clk_en)) else $error("enables moved");
    c_bank1_write: cover property (wr && paddr == 12'h104);
    c_deep_on: cover property (deep_sleep_mode && periph_clk_en != 0);
    c_unmapped: cover property (pslverr);
endmodule
bind pcg_peripheral_clock_gating pcg_checker #(.NUM_PERIPH(NUM_PERIPH))
    pcg_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .pslverr,
    .pclken,
    .sleep_mode, .deep_sleep_mode, .paddr, .pwdata, .prdata,
    .periph_access, .periph_clk_en, .periph_fault);

/* pcg_defines.vh */
// Purpose: Constants of the peripheral clock gating block.
// Assumes: APB register access, byte addresses, 32-bit data.
// Notes: Offsets are byte addresses of aligned words.
// Function
// - Set gate bit clocks its peripheral.
// - Clear gate bit stops peripheral clock.
// - Access to unclocked peripheral returns bus fault.
// - Gate bits reset to zero unless noted.
// - Run bank applies while processor runs.
// - Sleep and deep-sleep banks per index.
// - Low-power banks need auto gating select set.
// - Deep bank0: PWM 20, converter 16, watchdog 3.
// - Run bank1 bit 24 gates comparator zero.
// - Run bank1 bit 18 gates counter two.
// - Run bank1 bit 17 gates counter one.
// - Reserved bits read-only zero; software preserves them. The code keeps reserved bit 6 of bank0 fixed at one.
// - Deep bank0 resets to 0x00000040.
// - Run bank1 resets to all zeros.
`ifndef PCG_DEFINES_VH
`define PCG_DEFINES_VH

`define PCG_RUN_CLOCK_CONFIG 12'h060
`define PCG_RUN_GATE_BANK0 12'h100
`define PCG_RUN_GATE_BANK1 12'h104
`define PCG_SLEEP_GATE_BANK0 12'h110
`define PCG_SLEEP_GATE_BANK1 12'h114
`define PCG_DEEP_SLEEP_GATE_BANK0 12'h120
`define PCG_DEEP_SLEEP_GATE_BANK1 12'h124
`define PCG_CLOCK_STATUS 12'h130

`define PCG_BANK0_RESET 32'h00000040
`define PCG_BANK1_RESET 32'h00000000
`define PCG_RUN_CLOCK_CONFIG_RESET 32'h00000000

`define PCG_BANK0_WMASK 32'h00110308
`define PCG_BANK1_WMASK 32'h01060000
`define PCG_DEEP_BANK0_WMASK 32'h00110008
`define PCG_RUN_CLOCK_CONFIG_WMASK 32'h08000000

`define PCG_AUTO_GATING_BIT 27
`define PCG_WDT_BIT 3
`define PCG_ADC_BIT 16
`define PCG_PWM_BIT 20
`define PCG_COUNTER_ONE_BIT 17
`define PCG_COUNTER_TWO_BIT 18
`define PCG_COMPARATOR_ZERO_BIT 24

`define PCG_NUM_PERIPH 6
`define PCG_NUM_BANKS 2

`endif

/* pcg_peripheral_clock_gating.v */
// Purpose: Per-peripheral clock enables with run, sleep and deep banks.
// Assumes: Inputs are synchronous to pclk; the clock gate cells sit
//          outside and take the enables produced here.
// Notes: Enable order is watchdog, converter, pwm, counter one,
//        counter two, comparator zero.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`include "pcg_defines.vh"

module pcg_peripheral_clock_gating #(
    parameter NUM_PERIPH = `PCG_NUM_PERIPH
) (
    input wire pclk, // System clock.
    input wire presetn, // Asynchronous reset, active low.
    input wire pclken, // Clock enable; low freezes all state.
    input wire psel, // APB select.
    input wire penable, // APB enable.
    input wire pwrite, // APB direction, high for write.
    input wire [11:0] paddr, // APB byte address.
    input wire [31:0] pwdata, // APB write data.
    output reg [31:0] prdata, // APB read data.
    output wire pready, // APB ready.
    output wire pslverr, // APB error on unmapped address.
    input wire sleep_mode, // Processor is in sleep.
    input wire deep_sleep_mode, // Processor is in deep sleep.
    input wire [NUM_PERIPH-1:0] periph_access, // Bus access per unit.
    output reg [NUM_PERIPH-1:0] periph_clk_en, // Clock enable per unit.
    output wire [NUM_PERIPH-1:0] periph_fault // Bus fault per unit.
);

    localparam ST_RUN = 2'd0;
    localparam ST_SLEEP = 2'd1;
    localparam ST_DEEP = 2'd2;

    reg [31:0] run_clock_config;
    reg [1:0] power_state;
    reg [31:0] next_prdata;
    reg addr_hit;
    wire [31:0] run_word [0:`PCG_NUM_BANKS-1];
    wire [31:0] sleep_word [0:`PCG_NUM_BANKS-1];
    wire [31:0] deep_word [0:`PCG_NUM_BANKS-1];
    wire [31:0] eff_word [0:`PCG_NUM_BANKS-1];
    wire [NUM_PERIPH-1:0] next_clk_en;
    wire auto_gating_select;
    wire setup_phase;
    wire write_strobe;

    assign setup_phase = psel & ~penable;
    assign write_strobe = psel & penable & pwrite & addr_hit & pclken;
    assign auto_gating_select = run_clock_config[`PCG_AUTO_GATING_BIT];

    // Deep sleep outranks sleep when both are reported.
    always @* begin
        if (!auto_gating_select) begin
            power_state = ST_RUN;
        end else if (deep_sleep_mode) begin
            power_state = ST_DEEP;
        end else if (sleep_mode) begin
            power_state = ST_SLEEP;
        end else begin
            power_state = ST_RUN;
        end
    end

    always @* begin
        addr_hit = 1'b1;
        if (paddr == `PCG_RUN_CLOCK_CONFIG) begin
            next_prdata = run_clock_config;
        end else if (paddr == `PCG_RUN_GATE_BANK0) begin
            next_prdata = run_word[0];
        end else if (paddr == `PCG_RUN_GATE_BANK1) begin
            next_prdata = run_word[1];
        end else if (paddr == `PCG_SLEEP_GATE_BANK0) begin
            next_prdata = sleep_word[0];
        end else if (paddr == `PCG_SLEEP_GATE_BANK1) begin
            next_prdata = sleep_word[1];
        end else if (paddr == `PCG_DEEP_SLEEP_GATE_BANK0) begin
            next_prdata = deep_word[0];
        end else if (paddr == `PCG_DEEP_SLEEP_GATE_BANK1) begin
            next_prdata = deep_word[1];
        end else if (paddr == `PCG_CLOCK_STATUS) begin
            next_prdata = {{(32-NUM_PERIPH){1'b0}}, periph_clk_en};
        end else begin
            next_prdata = 32'h00000000;
            addr_hit = 1'b0;
        end
    end

    // Read data is captured in the setup cycle so that it comes from a
    // flip-flop while the access phase still completes without a wait.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (pclken && setup_phase && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;

    // Only the auto gating bit is writable; other bits read as zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_clock_config <= `PCG_RUN_CLOCK_CONFIG_RESET;
        end else if (write_strobe && paddr == `PCG_RUN_CLOCK_CONFIG) begin
            run_clock_config <= pwdata & `PCG_RUN_CLOCK_CONFIG_WMASK;
        end
    end

    genvar b;
    generate
        for (b = 0; b < `PCG_NUM_BANKS; b = b + 1) begin : g_bank
            localparam [31:0] RST = (b == 0) ? `PCG_BANK0_RESET :
                `PCG_BANK1_RESET;
            localparam [31:0] WMASK = (b == 0) ? `PCG_BANK0_WMASK :
                `PCG_BANK1_WMASK;
            // The deep bank 0 has no converter speed field to store.
            localparam [31:0] DP_WMASK = (b == 0) ? `PCG_DEEP_BANK0_WMASK :
                `PCG_BANK1_WMASK;
            localparam [11:0] RUN_ADDR = (b == 0) ? `PCG_RUN_GATE_BANK0 :
                `PCG_RUN_GATE_BANK1;
            localparam [11:0] SLP_ADDR = (b == 0) ? `PCG_SLEEP_GATE_BANK0 :
                `PCG_SLEEP_GATE_BANK1;
            localparam [11:0] DP_ADDR = (b == 0) ?
                `PCG_DEEP_SLEEP_GATE_BANK0 : `PCG_DEEP_SLEEP_GATE_BANK1;
            reg [31:0] run_gate;
            reg [31:0] sleep_gate;
            reg [31:0] deep_gate;

            // Reserved bits keep their reset value and ignore writes, so
            // they read back zero except the fixed bit 6 of bank 0.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    run_gate <= RST;
                    sleep_gate <= RST;
                    deep_gate <= RST;
                end else if (write_strobe) begin
                    if (paddr == RUN_ADDR) begin
                        run_gate <= (pwdata & WMASK) | (RST & ~WMASK);
                    end else if (paddr == SLP_ADDR) begin
                        sleep_gate <= (pwdata & WMASK) | (RST & ~WMASK);
                    end else if (paddr == DP_ADDR) begin
                        deep_gate <= (pwdata & DP_WMASK) |
                            (RST & ~DP_WMASK);
                    end
                end
            end

            assign run_word[b] = run_gate;
            assign sleep_word[b] = sleep_gate;
            assign deep_word[b] = deep_gate;
            assign eff_word[b] = (power_state == ST_DEEP) ? deep_gate :
                (power_state == ST_SLEEP) ? sleep_gate : run_gate;
        end
    endgenerate

    assign next_clk_en = {
        eff_word[1][`PCG_COMPARATOR_ZERO_BIT],
        eff_word[1][`PCG_COUNTER_TWO_BIT],
        eff_word[1][`PCG_COUNTER_ONE_BIT],
        eff_word[0][`PCG_PWM_BIT],
        eff_word[0][`PCG_ADC_BIT],
        eff_word[0][`PCG_WDT_BIT]
    };

    // Enables are registered so the outside gate cells see clean levels.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_clk_en <= {NUM_PERIPH{1'b0}};
        end else if (pclken) begin
            periph_clk_en <= next_clk_en;
        end
    end

    // A unit that is unclocked cannot answer, so its access faults here.
    assign periph_fault = periph_access & ~periph_clk_en;

endmodule

/* peripheral_clock_gating_test.sv */
// Purpose: Self-checking bench for the clock gating block.
// Assumes: Zero-wait slave; pclken high except for one write that must be ignored.
// Notes: Reads are queued and checked by a monitor.
`timescale 1ns/10ps
module peripheral_clock_gating_test;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg sleep_mode = 0, deep_sleep_mode = 0, pclken = 1;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rnd;
    reg [5:0] periph_access = 0, e6;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [5:0] periph_clk_en, periph_fault;
    reg [32:0] exp_q[$];
    integer n_fail = 0, total_checks = 0, seed = 32'hb830, i;
    always #2.5 pclk = ~pclk;
    pcg_peripheral_clock_gating pcg_peripheral_clock_gating_inst (.pclk,
        .presetn, .pclken, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sleep_mode, .deep_sleep_mode,
        .periph_access, .periph_clk_en, .periph_fault);
    task check(input [32:0] got, exp, input [63:0] what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %0s exp %h got %h", what, exp, got);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // An idle cycle follows each transfer so enables settle before reads.
    task apb(input w, input [11:0] a, input [31:0] d, input [32:0] e);
        integer n;
        n = 0;
        if (!w) exp_q.push_back(e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (n == 20) begin
            n_fail++;
            report_and_stop;
        end
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, exp_q.pop_front(), "read");
    task mode(input s, input d);
        sleep_mode <= s;
        deep_sleep_mode <= d;
        @(posedge pclk);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 12'h104, 0, 33'h0);
        apb(0, 12'h120, 0, 33'h40);
        apb(0, 12'h130, 0, 33'h0);
        apb(0, 12'h200, 0, 33'h100000000);
        apb(1, 12'h104, 32'hffffffff, 0);
        apb(0, 12'h104, 0, 33'h01060000);
        for (i = 0; i < 4; i++) begin
            rnd = $random(seed);
            e6 = {3'h7, rnd[20], rnd[16], rnd[3]};
            apb(1, 12'h100, rnd, 0);
            apb(0, 12'h130, 0, {27'h0, e6});
        end
        apb(1, 12'h104, 0, 0);
        pclken <= 0;
        apb(1, 12'h104, 32'hffffffff, 0);
        pclken <= 1;
        apb(0, 12'h104, 0, 33'h0);
        apb(1, 12'h120, 32'hffffffff, 0);
        apb(0, 12'h120, 0, 33'h00110048);
        apb(1, 12'h060, 32'h08000000, 0);
        mode(0, 1);
        apb(0, 12'h130, 0, 33'h07);
        mode(1, 0);
        apb(0, 12'h130, 0, 33'h0);
        apb(1, 12'h060, 0, 0);
        e6[5:3] = 0;
        apb(0, 12'h130, 0, {27'h0, e6});
        periph_access <= rnd[5:0];
        @(posedge pclk);
        check({27'h0, periph_fault}, {27'h0, rnd[5:0] & ~e6}, "fault");
        report_and_stop;
    end
endmodule
